// ===== mms_top.sv
/*
 Steering of data moves and program fetches between internal SRAM,
 a lock status byte and the multiplexed external bus, with APB registers.
 Assumes the core holds its request stable for the accepting edge only
 and that the external memory drives data while its strobe is low.
*/
// Chosen here: register access over APB.
// Contract
// - Two memory-select bits choose data-move steering, changeable anytime.
// - Select 00 sends all data moves to the external bus.
// - Select 01 maps 0000-03FF to SRAM, above that external.
// - Select 11: SRAM low, lock byte at FFFC, nothing external otherwise.
// - Lock byte low three bits show programmed locks; read-only.
// - Changing select bits never alters SRAM contents.
// - Stretch 0..7 held; external data move lasts stretch plus two cycles.
// - Stretch resets to one.
// - SRAM data moves always take two machine cycles.
// - External access drives multiplexed low address/data and high address.
// - Force pin low sends every fetch off-chip.
// - Program store strobe goes low for external fetches.
// - Shrinking program size sends beyond-limit fetches external at once.
// - Machine cycle is four clocks with at most one latch strobe each.
// - Latch strobe still pulses for external accesses when disabled.
`timescale 1ns/10ps
`default_nettype none

module mms_top (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [mms_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Core data-move request
  input  wire logic                       cpu_req,
  input  wire logic                       cpu_wr,
  input  wire logic [15:0]                cpu_addr,
  input  wire logic [7:0]                 cpu_wdata,
  output logic                            cpu_busy,
  output logic                            cpu_done,
  output logic      [7:0]                 cpu_rdata,
  // Core program fetch request
  input  wire logic                       fetch_req,
  input  wire logic [15:0]                fetch_addr,
  output logic                            fetch_done,
  output logic                            fetch_ext,
  output logic      [7:0]                 fetch_data,
  // Device pins and straps
  input  wire logic                       external_fetch_force_pin_n,
  input  wire logic [2:0]                 security_lock_status,
  input  wire logic [7:0]                 low_address_data_port_i,
  output logic      [7:0]                 low_address_data_port_o,
  output logic                            low_address_data_port_oe_n,
  output logic      [7:0]                 high_address_port_o,
  output logic                            high_address_port_oe_n,
  output logic                            bus_active,
  output logic                            latch_strobe,
  output logic                            program_store_strobe_n,
  output logic                            read_strobe_n,
  output logic                            write_strobe_n
);

  // ****************************************
  // Storage and state
  // ****************************************
  logic [7:0]           clock_and_stretch_control;
  logic [7:0]           program_size_select;
  logic [7:0]           power_and_memory_control;
  logic [7:0]           sram [1024];
  logic [1:0]           phase;
  logic [2:0]           mc_cnt;
  mms_pkg::mms_state_t  state;
  mms_pkg::mms_target_t target;
  mms_pkg::mms_target_t next_target;
  logic                 req_fetch;
  logic                 req_wr;
  logic [15:0]          req_addr;
  logic [7:0]           req_wdata;
  logic                 ea_meta;
  logic                 ea_sync;
  logic [2:0]           lock_meta;
  logic [2:0]           lock_sync;
  logic [7:0]           p0_meta;
  logic [7:0]           p0_sync;
  logic [7:0]           local_rd;
  logic [7:0]           reg_rd;
  logic                 reg_hit;
  logic                 fetch_goes_ext;
  logic                 mc_end;

  // ****************************************
  // Functions
  // ****************************************

  // Steering of one data-move address by the two select bits.
  function automatic mms_pkg::mms_target_t steer(input logic [15:0] a, input logic [1:0] sel);
    mms_pkg::mms_target_t t;
    t = mms_pkg::T_EXT;
    if (sel[0] && a <= mms_pkg::SRAM_TOP) begin
      t = mms_pkg::T_SRAM;
    end else if (sel == 2'b11) begin
      t = (a == mms_pkg::LOCK_ADDR) ? mms_pkg::T_LOCK : mms_pkg::T_NONE;
    end
    return t;
  endfunction

  // Internal program limit; codes above the largest clamp to full size.
  function automatic logic [16:0] prog_limit(input logic [2:0] code);
    logic [2:0] c;
    c = (code > 3'(mms_pkg::PSIZE_MAX)) ? 3'(mms_pkg::PSIZE_MAX) : code;
    // The shift is summed at five bits; three bits would wrap the base shift of nine.
    return (c == 3'h0) ? 17'h00000 : (17'h00001 << (5'(c) + 5'(mms_pkg::PSIZE_SH)));
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************

  // Straps and bus data come from outside the clock domain.
  always_ff @(posedge clk) begin
    ea_meta   <= external_fetch_force_pin_n;
    ea_sync   <= ea_meta;
    lock_meta <= security_lock_status;
    lock_sync <= lock_meta;
    p0_meta   <= low_address_data_port_i;
    p0_sync   <= p0_meta;
  end

  // ****************************************
  // Machine cycle timing
  // ****************************************

  // Free-running four-clock machine cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  assign mc_end = (phase == mms_pkg::LAST_PH);

  // ****************************************
  // APB register file
  // ****************************************

  // Read multiplexer; register index is the word address.
  always_comb begin
    reg_hit = (paddr[1:0] == 2'b00) && (paddr[mms_pkg::PADDR_W-1:10] == '0);
    reg_rd  = 8'h00;
    unique case (paddr[9:2])
      mms_pkg::CLOCK_AND_STRETCH_CONTROL_IDX: reg_rd = clock_and_stretch_control;
      mms_pkg::PSIZE_IDX: reg_rd = program_size_select;
      mms_pkg::PMR_IDX:   reg_rd = power_and_memory_control;
      mms_pkg::STAT_IDX:  reg_rd = {3'h0, lock_sync, ~ea_sync, bus_active};
      default:            reg_hit = 1'b0;
    endcase
  end

  // One wait-free access phase: answer is registered in the setup cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !reg_hit;
        prdata  <= reg_hit ? {24'h000000, reg_rd} : 32'h00000000;
      end
    end
  end

  // Writes land at the completing edge; the status word ignores writes.
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_and_stretch_control <= mms_pkg::CLOCK_AND_STRETCH_CONTROL_RST;
      program_size_select       <= mms_pkg::PSIZE_RST;
      power_and_memory_control  <= mms_pkg::PMR_RST;
    end else if (psel && penable && pready && pwrite && !pslverr) begin
      unique case (paddr[9:2])
        mms_pkg::CLOCK_AND_STRETCH_CONTROL_IDX: clock_and_stretch_control <= pwdata[7:0];
        mms_pkg::PSIZE_IDX: program_size_select       <= pwdata[7:0];
        mms_pkg::PMR_IDX:   power_and_memory_control  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Request decode
  // ****************************************

  // Decisions use the registers as they stand, so a shrink bites at once.
  always_comb begin
    next_target    = steer(cpu_addr, {power_and_memory_control[mms_pkg::MSEL_HI],
                                      power_and_memory_control[mms_pkg::MSEL_LO]});
    fetch_goes_ext = !ea_sync
                     || ({1'b0, fetch_addr} >= prog_limit(program_size_select[2:0]));
    unique case (target)
      mms_pkg::T_SRAM: local_rd = sram[req_addr[9:0]];
      mms_pkg::T_LOCK: local_rd = {5'h00, lock_sync};
      default:         local_rd = mms_pkg::NONE_DATA;
    endcase
  end

  // ****************************************
  // Access sequencer
  // ****************************************

  // Fetches win over data moves; each access starts on a cycle boundary.
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= mms_pkg::S_IDLE;
      target     <= mms_pkg::T_EXT;
      mc_cnt     <= 3'h0;
      req_fetch  <= 1'b0;
      req_wr     <= 1'b0;
      req_addr   <= 16'h0000;
      req_wdata  <= 8'h00;
      cpu_busy   <= 1'b0;
      cpu_done   <= 1'b0;
      cpu_rdata  <= 8'h00;
      fetch_done <= 1'b0;
      fetch_ext  <= 1'b0;
      fetch_data <= 8'h00;
    end else begin
      cpu_done   <= 1'b0;
      fetch_done <= 1'b0;
      unique case (state)
        mms_pkg::S_IDLE: begin
          if (fetch_req) begin
            req_fetch <= 1'b1;
            req_wr    <= 1'b0;
            req_addr  <= fetch_addr;
            target    <= mms_pkg::T_EXT;
            if (fetch_goes_ext) begin
              state    <= mms_pkg::S_ALIGN;
              cpu_busy <= 1'b1;
            end else begin
              // On-chip fetch: the core reads its own program store.
              fetch_done <= 1'b1;
              fetch_ext  <= 1'b0;
              fetch_data <= 8'h00;
            end
          end else if (cpu_req) begin
            req_fetch <= 1'b0;
            req_wr    <= cpu_wr;
            req_addr  <= cpu_addr;
            req_wdata <= cpu_wdata;
            target    <= next_target;
            state     <= mms_pkg::S_ALIGN;
            cpu_busy  <= 1'b1;
          end
        end
        mms_pkg::S_ALIGN: begin
          if (mc_end) begin
            state  <= (target == mms_pkg::T_EXT) ? mms_pkg::S_ADDR : mms_pkg::S_LOCAL;
            mc_cnt <= mms_pkg::LOCAL_MC - 3'h1;
          end
        end
        mms_pkg::S_ADDR: begin
          if (mc_end) begin
            state  <= mms_pkg::S_DATA;
            mc_cnt <= req_fetch ? 3'h0 : clock_and_stretch_control[2:0];
          end
        end
        mms_pkg::S_DATA: begin
          if (mc_end) begin
            if (mc_cnt == 3'h0) begin
              // Sampled while the strobe is still low.
              state    <= mms_pkg::S_IDLE;
              cpu_busy <= 1'b0;
              if (req_fetch) begin
                fetch_done <= 1'b1;
                fetch_ext  <= 1'b1;
                fetch_data <= p0_sync;
              end else begin
                cpu_done  <= 1'b1;
                cpu_rdata <= req_wr ? cpu_rdata : p0_sync;
              end
            end else begin
              mc_cnt <= mc_cnt - 3'h1;
            end
          end
        end
        mms_pkg::S_LOCAL: begin
          if (mc_end) begin
            if (mc_cnt == 3'h0) begin
              state     <= mms_pkg::S_IDLE;
              cpu_busy  <= 1'b0;
              cpu_done  <= 1'b1;
              cpu_rdata <= req_wr ? cpu_rdata : local_rd;
            end else begin
              mc_cnt <= mc_cnt - 3'h1;
            end
          end
        end
      endcase
    end
  end

  // SRAM has no reset, so select changes cannot disturb it.
  always_ff @(posedge clk) begin
    if (state == mms_pkg::S_LOCAL && mc_end && mc_cnt == 3'h0
        && req_wr && target == mms_pkg::T_SRAM) begin
      sram[req_addr[9:0]] <= req_wdata;
    end
  end

  // ****************************************
  // External bus pins
  // ****************************************

  // Pins change on the same edge as the sequencer transition that causes them.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_address_data_port_o    <= 8'h00;
      low_address_data_port_oe_n <= 1'b1;
      high_address_port_o        <= 8'h00;
      high_address_port_oe_n     <= 1'b1;
      bus_active                 <= 1'b0;
      program_store_strobe_n     <= 1'b1;
      read_strobe_n              <= 1'b1;
      write_strobe_n             <= 1'b1;
    end else if (state == mms_pkg::S_ALIGN && mc_end && target == mms_pkg::T_EXT) begin
      low_address_data_port_o    <= req_addr[7:0];
      low_address_data_port_oe_n <= 1'b0;
      high_address_port_o        <= req_addr[15:8];
      high_address_port_oe_n     <= 1'b0;
      bus_active                 <= 1'b1;
    end else if (state == mms_pkg::S_ADDR && mc_end) begin
      low_address_data_port_o    <= req_wdata;
      low_address_data_port_oe_n <= !req_wr;
      program_store_strobe_n     <= !req_fetch;
      read_strobe_n              <= req_fetch || req_wr;
      write_strobe_n             <= !req_wr;
    end else if (state == mms_pkg::S_DATA && mc_end && mc_cnt == 3'h0) begin
      low_address_data_port_oe_n <= 1'b1;
      high_address_port_oe_n     <= 1'b1;
      bus_active                 <= 1'b0;
      program_store_strobe_n     <= 1'b1;
      read_strobe_n              <= 1'b1;
      write_strobe_n             <= 1'b1;
    end
  end

  // Latch strobe: one clock per machine cycle, or only for external accesses when disabled; high in reset. It is held
  // low inside the data phase so data on the shared port is never latched.
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_strobe <= 1'b1;
    end else begin
      latch_strobe <= mc_end
                      && !(state == mms_pkg::S_ADDR)
                      && !(state == mms_pkg::S_DATA && mc_cnt != 3'h0)
                      && (!power_and_memory_control[mms_pkg::LATCH_STROBE_DISABLE_BIT]
                          || (state == mms_pkg::S_ALIGN && target == mms_pkg::T_EXT));
    end
  end

endmodule

`default_nettype wire

// ===== mms_pkg.sv
/*
 Constants and types for the data-move and program-fetch steering block.
 Assumes register indices map to APB byte addresses as index times four.
*/
`default_nettype none

package mms_pkg;

  // ****************************************
  // Register indices and bus layout
  // ****************************************
  localparam logic [7:0] CLOCK_AND_STRETCH_CONTROL_IDX  = 8'h8E;
  localparam logic [7:0] PSIZE_IDX  = 8'hC2;
  localparam logic [7:0] PMR_IDX    = 8'hC4;
  localparam logic [7:0] STAT_IDX   = 8'hC6;
  localparam int         PADDR_W    = 12;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] CLOCK_AND_STRETCH_CONTROL_RST  = 8'h01;
  localparam logic [7:0] PSIZE_RST  = 8'h05;
  localparam logic [7:0] PMR_RST    = 8'h00;
  localparam int         MSEL_LO    = 0;
  localparam int         MSEL_HI    = 1;
  localparam int         LATCH_STROBE_DISABLE_BIT = 2;
  localparam int         ST_BUSY    = 0;
  localparam int         ST_EAFORCE = 1;
  localparam int         ST_LOCK0   = 2;

  // ****************************************
  // Memory map and timing
  // ****************************************
  localparam logic [15:0] SRAM_TOP  = 16'h03FF;
  localparam logic [15:0] LOCK_ADDR = 16'hFFFC;
  localparam logic [7:0]  NONE_DATA = 8'h00;
  localparam logic [1:0]  LAST_PH   = 2'h3;
  localparam logic [2:0]  LOCAL_MC  = 3'h2;
  localparam int          PSIZE_MAX = 5;
  localparam int          PSIZE_SH  = 9;

  typedef enum logic [2:0] {S_IDLE, S_ALIGN, S_ADDR, S_DATA, S_LOCAL} mms_state_t;
  typedef enum logic [1:0] {T_EXT, T_SRAM, T_LOCK, T_NONE} mms_target_t;

endpackage

`default_nettype wire

// ===== mms_properties.sv
/*
 Checker for the steering block, bound to its top module.
 Assumes only the top module's ports and the package constants.
*/
`timescale 1ns/10ps
`default_nettype none

module mms_properties (
  // Clock, reset and register bus
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [mms_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  // External bus pins
  input wire logic                        low_address_data_port_oe_n,
  input wire logic [7:0]                  high_address_port_o,
  input wire logic                        high_address_port_oe_n,
  input wire logic                        bus_active,
  input wire logic                        latch_strobe,
  input wire logic                        program_store_strobe_n,
  input wire logic                        read_strobe_n,
  input wire logic                        write_strobe_n
);
  // ****************************************
  // Helper state and properties
  // ****************************************
  logic [2:0] stretch;
  logic [5:0] low_len;
  logic [2:0] warm;

  // Shadow of the stretch field; refused writes must not move it.
  always_ff @(posedge clk) begin
    if (rst)
      stretch <= mms_pkg::CLOCK_AND_STRETCH_CONTROL_RST[2:0];
    else if (psel && penable && pready && pwrite && !pslverr && paddr == {2'b00, mms_pkg::CLOCK_AND_STRETCH_CONTROL_IDX, 2'b00})
      stretch <= pwdata[2:0];
  end

  // Length of the current data strobe in clocks.
  always_ff @(posedge clk) begin
    if (rst || (read_strobe_n && write_strobe_n))
      low_len <= 6'h00;
    else
      low_len <= low_len + 6'h01;
  end

  // The latch strobe is forced high in reset, so its pacing is judged only once it settles.
  always_ff @(posedge clk) begin
    if (rst)
      warm <= 3'h0;
    else if (warm != 3'h4)
      warm <= warm + 3'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  apb_ready_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  apb_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned access accepted");
  latch_pace_a: assert property (latch_strobe && warm == 3'h4 |=> !latch_strobe [*3])
    else $error("latch strobe faster than one per machine cycle");
  ext_latch_a: assert property ($fell(low_address_data_port_oe_n) |-> latch_strobe)
    else $error("address driven without latch strobe");
  strobe_len_a: assert property ($rose(read_strobe_n && write_strobe_n) |-> low_len == {({1'b0, stretch} + 4'h1), 2'b00})
    else $error("data strobe length wrong for stretch");
  addr_hold_a: assert property (!read_strobe_n && $past(!read_strobe_n) |-> $stable(high_address_port_o))
    else $error("high address moved during read strobe");
  bus_owned_a: assert property (!(read_strobe_n && write_strobe_n && program_store_strobe_n) |-> bus_active && !high_address_port_oe_n)
    else $error("strobe active without bus ownership");
  read_float_a: assert property (!read_strobe_n |-> low_address_data_port_oe_n) else $error("port driven during read");

  cover property (!read_strobe_n);
  cover property (!write_strobe_n);
  cover property (!program_store_strobe_n);
endmodule

bind mms_top mms_properties mms_properties_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .low_address_data_port_oe_n(low_address_data_port_oe_n), .high_address_port_o(high_address_port_o),
  .high_address_port_oe_n(high_address_port_oe_n), .bus_active(bus_active), .latch_strobe(latch_strobe),
  .program_store_strobe_n(program_store_strobe_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n));

`default_nettype wire

// ===== mms_ext_mem.sv
/*
 Behavioural external memory on the multiplexed bus: 64k data bytes and a code store.
 Assumes the bench resolves the shared low port and feeds the resolved level back in.
*/
`timescale 1ns/10ps
`default_nettype none

module mms_ext_mem (
  // Clock and answer speed
  input  wire logic       clk,
  input  wire logic       slow,
  // Bus pins seen from the memory
  input  wire logic       latch_strobe,
  input  wire logic [7:0] bus,
  input  wire logic [7:0] high_addr,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       program_store_strobe_n,
  // Drive back onto the low port
  output logic            drive_en,
  output logic      [7:0] drive_q
);
  // ****************************************
  // Storage, address latch and read drive
  // ****************************************
  logic [7:0]  mem [0:65535];
  logic [15:0] lat;
  logic        seen;

  // Contents follow a simple address pattern so the bench can predict unwritten bytes.
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'hA5;

  // Like a transparent latch, the low byte is taken while the strobe is high.
  always @(posedge clk) begin
    if (latch_strobe)
      lat <= {high_addr, bus};
    if (!write_strobe_n)
      mem[lat] <= bus;
    seen <= !read_strobe_n;
  end

  // A slow part answers one clock late; the code store answers only under its strobe.
  assign drive_en = (!read_strobe_n && (seen || !slow)) || !program_store_strobe_n;
  assign drive_q  = !program_store_strobe_n ? lat[7:0] ^ 8'h3C : mem[lat];
endmodule

`default_nettype wire

// ===== tb.sv
/*
 Self-checking testbench for the steering block with an external memory model.
 Assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  // ****************************************
  // Stimulus, instances and bus resolution
  // ****************************************
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        cpu_req = 1'b0, cpu_wr = 1'b0, cpu_done, fetch_req = 1'b0, fetch_done, fetch_ext, e;
  logic [15:0] cpu_addr = 16'h0, fetch_addr = 16'h0;
  logic [7:0]  cpu_wdata = 8'h00, cpu_rdata, fetch_data, p0, p0_o, p0_last = 8'h00, hi_o, mem_q, rd;
  logic        force_n = 1'b1, slow = 1'b0, p0_oe_n, rd_n, wr_n, ps_n, ale, mem_en, busy;
  logic [2:0]  lock = 3'b101;
  int          miscompares = 0, cmp_count = 0, n, ext_cnt = 0, c;

  always #50 clk = ~clk;

  mms_top mms_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req), .cpu_wr(cpu_wr),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_busy(busy), .cpu_done(cpu_done), .cpu_rdata(cpu_rdata),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_done(fetch_done), .fetch_ext(fetch_ext),
    .fetch_data(fetch_data), .external_fetch_force_pin_n(force_n), .security_lock_status(lock),
    .low_address_data_port_i(p0), .low_address_data_port_o(p0_o), .low_address_data_port_oe_n(p0_oe_n),
    .high_address_port_o(hi_o), .high_address_port_oe_n(), .bus_active(), .latch_strobe(ale),
    .program_store_strobe_n(ps_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n));

  mms_ext_mem mms_ext_mem_inst (.clk(clk), .slow(slow), .latch_strobe(ale), .bus(p0), .high_addr(hi_o),
    .read_strobe_n(rd_n), .write_strobe_n(wr_n), .program_store_strobe_n(ps_n), .drive_en(mem_en), .drive_q(mem_q));

  // Nothing pulls the port in bus mode, so a released line shows the inverse of its last level.
  assign p0 = !p0_oe_n ? p0_o : mem_en ? mem_q : ~p0_last;
  always @(posedge clk) p0_last <= p0;

  // External strobe activity, used to prove that an access stayed off the bus.
  always @(posedge clk) if (!rd_n || !wr_n) ext_cnt <= ext_cnt + 1;

  function automatic logic [7:0] init(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("Compares %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; the request is held until ready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // One data move; n counts clocks from the accepting edge to the done sample.
  task mv(input logic w, input logic [15:0] a, input logic [7:0] d);
    cpu_req <= 1'b1;
    cpu_wr <= w;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 1) chk(busy, 1'b1);
    end while (cpu_done !== 1'b1);
    chk(busy, 1'b0);
    rd = cpu_rdata;
  endtask

  task fc(input logic [15:0] a, input logic x);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    fetch_req <= 1'b0;
    do @(posedge clk); while (fetch_done !== 1'b1);
    chk(fetch_ext, x);
    if (x) chk(fetch_data, a[7:0] ^ 8'h3C);
  endtask

  // Watchdog sized well above the several hundred clocks the sequence needs.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({p0_oe_n, rd_n, wr_n, ps_n}, 4'hF);
    apb(0, 12'h238, 0); chk(r, 32'h1);
    apb(0, 12'h308, 0); chk(r, 32'h5);
    apb(0, 12'h310, 0); chk(r, 32'h0);
    apb(0, 12'h318, 0); chk(r, 32'h14);
    apb(0, 12'h3FC, 0); chk(e, 1'b1);
    apb(1, 12'h23A, 7); chk(e, 1'b1);
    mv(1, 16'h0010, 8'h5A); chk(mms_ext_mem_inst.mem[16'h0010], 8'h5A);
    mv(0, 16'h0010, 0); chk(rd, 8'h5A); chk(n >= 13 && n <= 17, 1);
    apb(1, 12'h310, 4); // Latch strobe disabled, all data moves external.
    for (int s = 0; s < 8; s++) begin
      slow <= s[0];
      apb(1, 12'h238, s);
      mv(1, 16'h1200 + s, 8'h30 + s);
      mv(0, 16'h1200 + s, 0); chk(rd, 8'h30 + s); chk(n >= 4 * s + 9 && n <= 4 * s + 13, 1);
    end
    apb(1, 12'h310, 1);
    mv(1, 16'h03FF, 8'hC3);
    mv(0, 16'h03FF, 0); chk(rd, 8'hC3); chk(n >= 9 && n <= 13, 1);
    chk(mms_ext_mem_inst.mem[16'h03FF], init(16'h03FF));
    mv(0, 16'h0400, 0); chk(rd, init(16'h0400));
    apb(1, 12'h310, 0);
    mv(0, 16'h03FF, 0); chk(rd, init(16'h03FF));
    apb(1, 12'h310, 3);
    c = ext_cnt;
    mv(0, 16'h03FF, 0); chk(rd, 8'hC3);
    mv(0, 16'hFFFC, 0); chk(rd, 8'h05);
    mv(1, 16'hFFFC, 8'hFF);
    mv(0, 16'hFFFC, 0); chk(rd, 8'h05);
    mv(1, 16'h0500, 8'h77);
    mv(0, 16'h0500, 0); chk(rd, 8'h00); chk(ext_cnt, c);
    fc(16'h0100, 0);
    fc(16'h3FFF, 0);
    fc(16'h4000, 1);
    apb(1, 12'h308, 3);
    fc(16'h1000, 1);
    fc(16'h0FFF, 0);
    force_n <= 1'b0;
    lock <= 3'b010;
    repeat (3) @(posedge clk);
    fc(16'h0100, 1);
    mv(0, 16'hFFFC, 0); chk(rd, 8'h02);
    apb(0, 12'h318, 0); chk(r, 32'h0A);
    finish_test;
  end
endmodule

`default_nettype wire
